// ---- src/ldo_regulator_control_regs.sv ----
// Control registers, hibernate, sequencing and fault handling for the second and third regulators.
`timescale 1ns/1ns
`include "ldo_regs_defs.svh"
module ldo_regulator_control_regs #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES,
  parameter logic [4:0] VCODE_DEFAULT = `RST_VCODE,
  parameter logic [3:0] START_SLOT_DEFAULT = `RST_START_SLOT
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Power state machine requests.
  input wire logic power_up_i,
  input wire logic power_down_i,
  input wire logic sm_reset_i,
  // Hibernate sources.
  input wire logic hibernate_bit_i,
  input wire logic low_power_input_1_i,
  input wire logic low_power_input_2_i,
  input wire logic low_power_input_3_i,
  // Other regulators and fault.
  input wire logic reg1_enabled_i,
  input wire logic reg4_enabled_i,
  input wire logic reg2_enabled_i,
  input wire logic reg3_fault_i,
  // Regulator controls.
  output logic [4:0] reg2_vcode_o,
  output logic reg2_enable_o,
  output logic reg3_enable_o,
  output logic [4:0] reg3_vcode_o,
  output logic reg3_switch_o,
  output logic reg3_discharge_o,
  output logic system_shutdown_o,
  output logic irq_o
);
  import ldo_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map as seen by software:
  //   low-power word of the second regulator: behaviour 13:12, source 9:8, image code 4:0;
  //   control word of the third regulator: switch 14, float 10, voltage code 4:0;
  //   sequencing word of the third regulator: fault action 15:14, start slot 13:10, stop slot 9:6;
  //   interrupt status and mask words: fault in bit 0, sequence done in bit 1;
  //   state word, read only: regulator on 12, slot 11:8, one-hot state 3:0.
  // Bits that hold no field read as zero and ignore what is written to them.
  // Only the power state machine or a full reset restores defaults; a variant picks the voltage code and start slot defaults by parameter.
  // Register fields.
  logic [1:0] reg2_hibernate_behaviour;
  logic [1:0] reg2_hibernate_source;
  vcode_t reg2_image_voltage_code;
  logic reg3_switch_mode;
  logic reg3_output_float;
  vcode_t reg3_voltage_code;
  logic [1:0] reg3_fault_action;
  slot_t reg3_startup_slot;
  slot_t reg3_shutdown_slot;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  // Sequencer state and the controls derived from it.
  seq_state_e state;
  seq_state_e next_state;
  slot_t slot;
  logic slot_tick;
  logic reg3_on;
  logic reg2_hib;
  logic reg3_fault_kill;
  logic [1:0] irq_set;
  logic last_slot;

  // Millivolt value of a code, used only for the third regulator's voltage code check.
  // The lower half of the codes steps finely for core rails, the upper half coarsely for I/O rails.
  function automatic logic [11:0] code_to_mv(input vcode_t code);
    if (!code[4]) begin
      code_to_mv = 12'(900 + 50 * int'(code[3:0]));
    end else begin
      code_to_mv = 12'(1800 + 100 * int'(code[3:0]));
    end
  endfunction

  // Hibernate source select.
  function automatic logic pick_source(input logic [1:0] sel, input logic b, input logic p1, input logic p2,
                                       input logic p3);
    unique case (sel)
      2'h0: pick_source = b;
      2'h1: pick_source = p1;
      2'h2: pick_source = p2;
      2'h3: pick_source = p3;
    endcase
  endfunction

  logic [11:0] reg3_mv;
  assign reg3_mv = code_to_mv(reg3_voltage_code);

  ////////////////////////////////////////////////////////////////////////////////
  // Fields are written by software, but only the power state machine or a full reset restores defaults.
  // A write updates every field of the addressed word at once; fields cannot be written singly.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || sm_reset_i) begin
      reg2_hibernate_behaviour <= 2'h0;
      reg2_hibernate_source <= 2'h0;
      reg2_image_voltage_code <= `RST_IMAGE_CODE;
      reg3_switch_mode <= 1'b0;
      reg3_output_float <= 1'b0;
      reg3_voltage_code <= VCODE_DEFAULT;
      reg3_fault_action <= `RST_FAULT_ACT;
      reg3_startup_slot <= START_SLOT_DEFAULT;
      reg3_shutdown_slot <= `RST_STOP_SLOT;
    end else if (wr_i) begin
      unique case (addr_i)
        `ADDR_REG2_LOW_POWER: begin
          reg2_hibernate_behaviour <= wdata_i[`HIB_BEHAV_MSB:`HIB_BEHAV_LSB];
          reg2_hibernate_source <= wdata_i[`HIB_SRC_MSB:`HIB_SRC_LSB];
          reg2_image_voltage_code <= wdata_i[`VCODE_MSB:`VCODE_LSB];
        end
        `ADDR_REG3_CONTROL: begin
          reg3_switch_mode <= wdata_i[`SWITCH_BIT];
          reg3_output_float <= wdata_i[`FLOAT_BIT];
          reg3_voltage_code <= wdata_i[`VCODE_MSB:`VCODE_LSB];
        end
        `ADDR_REG3_SEQUENCING: begin
          reg3_fault_action <= wdata_i[`FAULT_ACT_MSB:`FAULT_ACT_LSB];
          reg3_startup_slot <= wdata_i[`START_SLOT_MSB:`START_SLOT_LSB];
          reg3_shutdown_slot <= wdata_i[`STOP_SLOT_MSB:`STOP_SLOT_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The tick that closes the last slot ends either sequence and raises the done event.
  assign last_slot = slot_tick && (slot == 4'(`SLOT_COUNT));

  // Interrupt events: every fault cycle counts, whatever the fault action says.
  assign irq_set[`IRQ_FAULT_BIT] = reg3_fault_i;
  assign irq_set[`IRQ_SEQ_DONE_BIT] = last_slot;

  // Sticky status; hardware set wins over a write-one clear in the same cycle, so no event is lost.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~((wr_i && addr_i == `ADDR_IRQ_STATUS) ? wdata_i[1:0] : 2'h0)) | irq_set;
    end
  end

  // Mask of the same layout; a set bit lets its status bit reach the interrupt line.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_mask <= 2'h0;
    end else if (wr_i && addr_i == `ADDR_IRQ_MASK) begin
      irq_mask <= wdata_i[1:0];
    end
  end

  // Level interrupt, registered so it leaves straight from a flip-flop.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port, data stand in the cycle after the strobe; unmapped reads give zero.
  // Reads have no side effects, so software may poll the status word freely.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0;
    end else if (rd_i) begin
      unique case (addr_i)
        `ADDR_REG2_LOW_POWER: rdata_o <= {2'h0, reg2_hibernate_behaviour, 2'h0, reg2_hibernate_source,
                                          3'h0, reg2_image_voltage_code};
        `ADDR_REG3_CONTROL: rdata_o <= {1'b0, reg3_switch_mode, 3'h0, reg3_output_float, 5'h0, reg3_voltage_code};
        `ADDR_REG3_SEQUENCING: rdata_o <= {reg3_fault_action, reg3_startup_slot, reg3_shutdown_slot, 6'h0};
        `ADDR_IRQ_STATUS: rdata_o <= {14'h0, irq_status};
        `ADDR_IRQ_MASK: rdata_o <= {14'h0, irq_mask};
        `ADDR_STATE: rdata_o <= {3'h0, reg3_on, slot, 4'h0, state};
        default: rdata_o <= 16'h0;
      endcase
    end else begin
      rdata_o <= 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: fourteen ascending slots each way, paced by the slot divider.
  // The divider is held while the sequencer rests, so every sequence starts on a fresh slot.
  slot_timer #(.CYCLES(SLOT_CYCLES)) u_slot_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(state == SEQ_START || state == SEQ_STOP),
    .tick_o(slot_tick)
  );

  // Requests outside the state that takes them are ignored; a system fault ends the active state.
  always_comb begin
    next_state = state;
    unique case (state)
      SEQ_OFF: if (power_up_i) next_state = SEQ_START;
      SEQ_START: if (last_slot) next_state = SEQ_ACTIVE;
      SEQ_ACTIVE: if (power_down_i || reg3_fault_kill) next_state = SEQ_STOP;
      SEQ_STOP: if (last_slot) next_state = SEQ_OFF;
    endcase
  end

  // Slot numbering restarts at one on every sequence and rests at zero outside them.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= SEQ_OFF;
      slot <= 4'h0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        slot <= (next_state == SEQ_START || next_state == SEQ_STOP) ? 4'h1 : 4'h0;
      end else if (slot_tick) begin
        slot <= slot + 4'h1;
      end
    end
  end

  // A system-level fault action drives the whole system down and stays until reset.
  assign reg3_fault_kill = reg3_fault_i && reg3_fault_action[1];

  // Third regulator enable follows its slots; a regulator-level fault drops it at once.
  // The fault outranks a slot that matches in the same cycle, so a faulty rail is not switched
  // back on; it waits for the next start sequence.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg3_on <= 1'b0;
    end else if (reg3_fault_i && reg3_fault_action == 2'h1) begin
      reg3_on <= 1'b0;
    end else if (state == SEQ_START && slot_tick && slot == reg3_startup_slot) begin
      reg3_on <= 1'b1;
    end else if (next_state == SEQ_ACTIVE && state != SEQ_ACTIVE && reg3_startup_slot == 4'hf) begin
      reg3_on <= 1'b1;
    end else if (state == SEQ_STOP && slot_tick && slot == reg3_shutdown_slot) begin
      reg3_on <= 1'b0;
    end else if (next_state == SEQ_OFF && state != SEQ_OFF) begin
      reg3_on <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hibernate of the second regulator follows the selected source level.
  // The source is a level, so the regulator leaves hibernate one cycle after it falls.
  assign reg2_hib = pick_source(reg2_hibernate_source, hibernate_bit_i, low_power_input_1_i,
                                low_power_input_2_i, low_power_input_3_i);

  // Second regulator outputs; reserved behaviour codes leave the regulator in normal operation.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg2_vcode_o <= 5'h0;
      reg2_enable_o <= 1'b1;
    end else begin
      reg2_vcode_o <= (reg2_hib && reg2_hibernate_behaviour == 2'h0) ? reg2_image_voltage_code
                                                                     : 5'h0;
      reg2_enable_o <= !(reg2_hib && reg2_hibernate_behaviour == 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Third regulator outputs, one cycle behind the fields and the enable state.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg3_enable_o <= 1'b0;
      reg3_vcode_o <= 5'h0;
      reg3_switch_o <= 1'b0;
    end else begin
      reg3_enable_o <= reg3_on;
      // The code is meaningless to a switch, so a zero code is shown in switch mode.
      reg3_vcode_o <= reg3_switch_mode ? 5'h0 : (reg3_mv != 12'h0 ? reg3_voltage_code : 5'h0);
      reg3_switch_o <= reg3_switch_mode;
    end
  end

  // Discharge while off; the all-off override protects a rail that every regulator has let go of.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg3_discharge_o <= 1'b1;
    end else begin
      reg3_discharge_o <= !reg3_on && (!reg3_output_float ||
                          !(reg1_enabled_i || reg2_enabled_i || reg4_enabled_i));
    end
  end

  // System shutdown is sticky; only a full reset brings the system back, not a field reset.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      system_shutdown_o <= 1'b0;
    end else if (reg3_fault_kill) begin
      system_shutdown_o <= 1'b1;
    end
  end
endmodule // ldo_regulator_control_regs

// ---- src/ldo_regs_defs.svh ----
// Register offsets, field positions, reset values and timing counts for the regulator control bank.
`ifndef LDO_REGS_DEFS_SVH
`define LDO_REGS_DEFS_SVH

`define ADDR_REG2_LOW_POWER 8'hcd
`define ADDR_REG3_CONTROL 8'hce
`define ADDR_REG3_SEQUENCING 8'hcf
`define ADDR_IRQ_STATUS 8'hd8
`define ADDR_IRQ_MASK 8'hd9
`define ADDR_STATE 8'hda

`define HIB_BEHAV_MSB 13
`define HIB_BEHAV_LSB 12
`define HIB_SRC_MSB 9
`define HIB_SRC_LSB 8
`define VCODE_MSB 4
`define VCODE_LSB 0
`define SWITCH_BIT 14
`define FLOAT_BIT 10
`define FAULT_ACT_MSB 15
`define FAULT_ACT_LSB 14
`define START_SLOT_MSB 13
`define START_SLOT_LSB 10
`define STOP_SLOT_MSB 9
`define STOP_SLOT_LSB 6

`define RST_IMAGE_CODE 5'h1c
`define RST_VCODE 5'h1b
`define RST_START_SLOT 4'h1
`define RST_STOP_SLOT 4'h0
`define RST_FAULT_ACT 2'h0

`define SLOT_COUNT 14
`define SLOT_TIME_US 2000
`define CLK_MHZ 10
`define SLOT_CYCLES (`SLOT_TIME_US * `CLK_MHZ)

`define IRQ_FAULT_BIT 0
`define IRQ_SEQ_DONE_BIT 1

`endif

// ---- src/ldo_regs_pkg.sv ----
// Types shared by the regulator control bank.
package ldo_regs_pkg;
  typedef enum logic [3:0] {
    SEQ_OFF = 4'b0001,
    SEQ_START = 4'b0010,
    SEQ_ACTIVE = 4'b0100,
    SEQ_STOP = 4'b1000
  } seq_state_e;
  typedef logic [4:0] vcode_t;
  typedef logic [3:0] slot_t;
endpackage

// ---- src/slot_timer.sv ----
// Slot pacing divider that emits a one-cycle tick per sequencer slot.
`timescale 1ns/1ns
module slot_timer #(
  parameter int CYCLES = 20000
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic run_i,
  output logic tick_o
);
  logic [31:0] count;

  // Counter restarts whenever the sequencer is idle so every slot is full length.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !run_i) begin
      // The registered tick lands one cycle after the last count, so a run starts one count ahead.
      // Without this the first slot of every sequence would be one cycle longer than the rest.
      count <= (CYCLES > 1) ? 32'h1 : 32'h0;
      tick_o <= 1'b0;
    end else if (count == 32'(CYCLES - 1)) begin
      count <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule // slot_timer

// ---- verification/ldo_regs_chk.sv ----
// Port-level checks for the regulator control bank.
`timescale 1ns/1ns
module ldo_regs_chk #(
  parameter int SLOT_CYCLES = 20000
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Watched inputs.
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic sm_reset_i,
  input wire logic power_up_i,
  input wire logic hibernate_bit_i,
  input wire logic low_power_input_1_i,
  input wire logic low_power_input_2_i,
  input wire logic low_power_input_3_i,
  input wire logic reg1_enabled_i,
  input wire logic reg2_enabled_i,
  input wire logic reg4_enabled_i,
  // Watched outputs.
  input wire logic [15:0] rdata_o,
  input wire logic [4:0] reg2_vcode_o,
  input wire logic reg2_enable_o,
  input wire logic reg3_enable_o,
  input wire logic [4:0] reg3_vcode_o,
  input wire logic reg3_switch_o,
  input wire logic reg3_discharge_o,
  input wire logic system_shutdown_o,
  input wire logic irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Quiet sources and an all-off supply are the causes the checks below depend on.
  wire logic no_hib = !hibernate_bit_i && !low_power_input_1_i && !low_power_input_2_i && !low_power_input_3_i;
  wire logic all_off = !reg1_enabled_i && !reg2_enabled_i && !reg4_enabled_i && !reg3_enable_o;
  ////////////////////////////////////////////////////////////////////////////////
  property p_switch_code;
    reg3_switch_o |-> reg3_vcode_o == 5'h00;
  endproperty
  a_switch_code: assert property (p_switch_code) else $error("switch mode with a voltage code");
  property p_disable_code;
    !reg2_enable_o |-> reg2_vcode_o == 5'h00;
  endproperty
  a_disable_code: assert property (p_disable_code) else $error("disabled output with an image code");
  property p_idle_hib;
    no_hib [*2] |-> reg2_enable_o && reg2_vcode_o == 5'h00;
  endproperty
  a_idle_hib: assert property (p_idle_hib) else $error("hibernate held with no source");
  property p_on_no_dis;
    reg3_enable_o && $past(reg3_enable_o) |-> !reg3_discharge_o;
  endproperty
  a_on_no_dis: assert property (p_on_no_dis) else $error("discharge while enabled");
  property p_all_off;
    all_off ##1 !reg3_enable_o |-> reg3_discharge_o;
  endproperty
  a_all_off: assert property (p_all_off) else $error("no discharge with all regulators off");
  property p_sticky;
    system_shutdown_o && !sm_reset_i |=> system_shutdown_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("system shutdown dropped");
  property p_smreset;
    (sm_reset_i && !wr_i) ##1 !wr_i |=> !reg3_switch_o;
  endproperty
  a_smreset: assert property (p_smreset) else $error("mode kept after state machine reset");
  property p_rdata_idle;
    !rd_i |=> rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  // Main scenarios reached.
  c_start: cover property (power_up_i ##[1:100] reg3_enable_o);
  c_irq: cover property ($rose(irq_o));
  c_shut: cover property ($rose(system_shutdown_o));
endmodule // ldo_regs_chk

bind ldo_regulator_control_regs ldo_regs_chk #(.SLOT_CYCLES(SLOT_CYCLES)) u_ldo_regs_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i), .sm_reset_i(sm_reset_i),
  .power_up_i(power_up_i), .hibernate_bit_i(hibernate_bit_i), .low_power_input_1_i(low_power_input_1_i),
  .low_power_input_2_i(low_power_input_2_i), .low_power_input_3_i(low_power_input_3_i),
  .reg1_enabled_i(reg1_enabled_i), .reg2_enabled_i(reg2_enabled_i), .reg4_enabled_i(reg4_enabled_i),
  .rdata_o(rdata_o), .reg2_vcode_o(reg2_vcode_o), .reg2_enable_o(reg2_enable_o), .reg3_enable_o(reg3_enable_o),
  .reg3_vcode_o(reg3_vcode_o), .reg3_switch_o(reg3_switch_o), .reg3_discharge_o(reg3_discharge_o),
  .system_shutdown_o(system_shutdown_o), .irq_o(irq_o));

// ---- verification/tb_ldo_regulator_control_regs.sv ----
// Self-checking bench for the regulator control bank.
`timescale 1ns/1ns
`include "ldo_regs_defs.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_ldo_regulator_control_regs;
  import ldo_regs_pkg::*;
  logic ref_clk_i, rst_n_i, wr_i, rd_i, power_up_i, power_down_i, sm_reset_i, reg3_fault_i, rd_d;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata_o, g, e;
  logic [3:0] hsrc;
  logic [2:0] oth;
  logic [4:0] reg2_vcode_o, reg3_vcode_o;
  logic reg2_enable_o, reg3_enable_o, reg3_switch_o, reg3_discharge_o, system_shutdown_o, irq_o;
  logic [31:0] rng = 32'h4;
  logic [15:0] exp_q[$];
  int sel_q[$];
  int checked = 0;
  int fail_count = 0;
  // Readable bits of the three registers and their values after a state machine reset.
  localparam logic [15:0] MSK [3] = '{16'h331f, 16'h441f, 16'hffc0};
  localparam logic [15:0] DFLT [3] = '{16'h001c, 16'h001b, 16'h0400};
  ldo_regulator_control_regs #(.SLOT_CYCLES(4)) u_ldo_regulator_control_regs (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .power_up_i(power_up_i), .power_down_i(power_down_i), .sm_reset_i(sm_reset_i),
    .hibernate_bit_i(hsrc[0]), .low_power_input_1_i(hsrc[1]), .low_power_input_2_i(hsrc[2]),
    .low_power_input_3_i(hsrc[3]), .reg1_enabled_i(oth[0]), .reg4_enabled_i(oth[2]), .reg2_enabled_i(oth[1]),
    .reg3_fault_i(reg3_fault_i), .reg2_vcode_o(reg2_vcode_o), .reg2_enable_o(reg2_enable_o),
    .reg3_enable_o(reg3_enable_o), .reg3_vcode_o(reg3_vcode_o), .reg3_switch_o(reg3_switch_o),
    .reg3_discharge_o(reg3_discharge_o), .system_shutdown_o(system_shutdown_o), .irq_o(irq_o));
  ////////////////////////////////////////////////////////////////////////////////
  // Output groups that a note may name.
  function automatic logic [15:0] obs(input int sel);
    case (sel)
      2: obs = {10'h0, reg2_enable_o, reg2_vcode_o};
      3: obs = {8'h0, reg3_enable_o, reg3_switch_o, reg3_discharge_o, reg3_vcode_o};
      default: obs = {14'h0, system_shutdown_o, irq_o};
    endcase
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // Read data exist only in the cycle after the strobe, so the monitor tracks that cycle.
  always @(posedge ref_clk_i) begin
    rd_d <= rd_i;
  end
  // Outputs are compared at the falling edge, well clear of the launching edge.
  always @(negedge ref_clk_i) begin
    if (rd_d) begin
      void'(sel_q.pop_front());
      e = exp_q.pop_front();
      `CHK(rdata_o, e)
    end
    while (sel_q.size() > 0 && sel_q[0] != 0) begin
      g = obs(sel_q.pop_front());
      e = exp_q.pop_front();
      `CHK(g, e)
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    sel_q.push_back(0);
    exp_q.push_back(x);
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
  endtask
  // Outputs lag by up to two edges, so a note is taken three edges on.
  task automatic peek(input int sel, input logic [15:0] x);
    repeat (3) @(posedge ref_clk_i);
    sel_q.push_back(sel);
    exp_q.push_back(x);
  endtask
  task automatic pulse(input int w);
    @(posedge ref_clk_i);
    {reg3_fault_i, sm_reset_i, power_down_i, power_up_i} <= 4'h1 << w;
    @(posedge ref_clk_i);
    {reg3_fault_i, sm_reset_i, power_down_i, power_up_i} <= 4'h0;
  endtask
  task automatic results();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2500) @(posedge ref_clk_i);
    fail_count++;
    results();
  end
  initial begin
    {rst_n_i, wr_i, rd_i, power_up_i, power_down_i, sm_reset_i, reg3_fault_i} = 7'h00;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    hsrc = 4'h0;
    oth = 3'h7;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      rd(8'hcd + 8'(j), DFLT[j]);
    end
    rd(8'h10, 16'h0000);
    $display("defaults done");
    // Random words read back through the masks, then a state machine reset restores defaults.
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      wr(8'hcd + 8'(i % 3), rng[15:0]);
      rd(8'hcd + 8'(i % 3), rng[15:0] & MSK[i % 3]);
    end
    pulse(2);
    for (int j = 0; j < 3; j++) begin
      rd(8'hcd + 8'(j), DFLT[j]);
    end
    $display("registers done");
    // Only the selected source may trigger the image voltage.
    for (int s = 0; s < 4; s++) begin
      wr(`ADDR_REG2_LOW_POWER, {6'h00, 2'(s), 3'h0, 5'h12});
      hsrc <= ~(4'h1 << s);
      peek(2, 16'h0020);
      hsrc <= 4'h1 << s;
      peek(2, 16'h0032);
    end
    wr(`ADDR_REG2_LOW_POWER, 16'h1012);
    hsrc <= 4'h1;
    peek(2, 16'h0000);
    hsrc <= 4'h0;
    peek(2, 16'h0020);
    wr(`ADDR_REG2_LOW_POWER, 16'h2012);
    hsrc <= 4'h1;
    peek(2, 16'h0020);
    hsrc <= 4'h0;
    $display("hibernate done");
    wr(`ADDR_REG3_CONTROL, 16'h4415);
    peek(3, 16'h0040);
    wr(`ADDR_REG3_CONTROL, 16'h0015);
    peek(3, 16'h0035);
    wr(`ADDR_REG3_CONTROL, 16'h0415);
    oth <= 3'h0;
    peek(3, 16'h0035);
    oth <= 3'h7;
    $display("control done");
    // Start in slot 3, stop in slot 2, with four cycles to a slot.
    wr(`ADDR_REG3_SEQUENCING, 16'h0c80);
    pulse(0);
    peek(3, 16'h0015);
    repeat (16) @(posedge ref_clk_i);
    peek(3, 16'h0095);
    repeat (50) @(posedge ref_clk_i);
    pulse(1);
    peek(3, 16'h0095);
    repeat (10) @(posedge ref_clk_i);
    peek(3, 16'h0015);
    repeat (60) @(posedge ref_clk_i);
    pulse(0);
    repeat (70) @(posedge ref_clk_i);
    peek(3, 16'h0095);
    rd(`ADDR_STATE, 16'h1004);
    rd(`ADDR_IRQ_STATUS, 16'h0002);
    // Start on entering active and stop on entering off, far from any numbered slot.
    wr(`ADDR_REG3_SEQUENCING, 16'h3c00);
    pulse(1);
    repeat (40) @(posedge ref_clk_i);
    peek(3, 16'h0095);
    repeat (20) @(posedge ref_clk_i);
    peek(3, 16'h0015);
    pulse(0);
    repeat (40) @(posedge ref_clk_i);
    peek(3, 16'h0015);
    repeat (20) @(posedge ref_clk_i);
    peek(3, 16'h0095);
    $display("sequencing done");
    wr(`ADDR_IRQ_STATUS, 16'h0003);
    wr(`ADDR_IRQ_MASK, 16'h0001);
    pulse(3);
    peek(4, 16'h0001);
    peek(3, 16'h0095);
    rd(`ADDR_IRQ_STATUS, 16'h0001);
    wr(`ADDR_IRQ_MASK, 16'h0000);
    peek(4, 16'h0000);
    wr(`ADDR_IRQ_MASK, 16'h0001);
    wr(`ADDR_IRQ_STATUS, 16'h0001);
    peek(4, 16'h0000);
    wr(`ADDR_REG3_SEQUENCING, 16'h4c80);
    pulse(3);
    peek(3, 16'h0015);
    wr(`ADDR_REG3_SEQUENCING, 16'h8c80);
    pulse(3);
    peek(4, 16'h0003);
    repeat (2) @(posedge ref_clk_i);
    $display("faults done");
    results();
  end
endmodule // tb_ldo_regulator_control_regs
